/* File: common/gpt_clk_if.sv */
`timescale 1ns/1ns
interface gpt_clk_if;
   logic       run;
   logic       gate;
   logic       src;
   logic       sync;
   logic [1:0] pre_sel;
   logic       tick;

   modport ctrl (output run, output gate, output src, output sync, output pre_sel, input tick);
   modport unit (input run, input gate, input src, input sync, input pre_sel, output tick);
endinterface

/* File: common/gpt_pkg.sv */
package gpt_pkg;
   // *****************************
   // register map and fields
   // *****************************
   localparam int          GPT_AW        = 4;
   localparam int          GPT_DW        = 16;
   localparam logic [3:0]  GPT_CNT_A     = 4'h0;
   localparam logic [3:0]  GPT_PER_A     = 4'h1;
   localparam logic [3:0]  GPT_CON_A     = 4'h2;
   localparam logic [3:0]  GPT_CNT_B     = 4'h3;
   localparam logic [3:0]  GPT_PER_B     = 4'h4;
   localparam logic [3:0]  GPT_CON_B     = 4'h5;
   localparam logic [3:0]  GPT_CNT_C     = 4'h6;
   localparam logic [3:0]  GPT_PER_C     = 4'h7;
   localparam logic [3:0]  GPT_CON_C     = 4'h8;
   localparam logic [3:0]  GPT_FLAGS     = 4'h9;
   localparam int          GPT_RUN_BIT   = 15;
   localparam int          GPT_HALT_BIT  = 13;
   localparam int          GPT_GATE_BIT  = 6;
   localparam int          GPT_PRE_HI    = 5;
   localparam int          GPT_PRE_LO    = 4;
   localparam int          GPT_PAIR_BIT  = 3;
   localparam int          GPT_SYNC_BIT  = 2;
   localparam int          GPT_SRC_BIT   = 1;
   localparam logic [15:0] GPT_MASK_A    = 16'ha076;
   localparam logic [15:0] GPT_MASK_B    = 16'ha07a;
   localparam logic [15:0] GPT_MASK_C    = 16'ha072;
   localparam logic [15:0] GPT_CON_RST   = 16'h0000;
   localparam logic [15:0] GPT_CNT_RST   = 16'h0000;
   localparam logic [15:0] GPT_PER_RST   = 16'hffff;
   localparam logic [7:0]  GPT_LAST_1    = 8'h00;
   localparam logic [7:0]  GPT_LAST_8    = 8'h07;
   localparam logic [7:0]  GPT_LAST_64   = 8'h3f;
   localparam logic [7:0]  GPT_LAST_256  = 8'hff;

   typedef enum {GPT_VAR_A, GPT_VAR_B, GPT_VAR_C} gpt_variant_e;

   // *****************************
   // shared decode
   // *****************************
   function automatic logic [7:0] gpt_pre_last(input logic [1:0] sel);
      case (sel)
         2'h0:    gpt_pre_last = GPT_LAST_1;
         2'h1:    gpt_pre_last = GPT_LAST_8;
         2'h2:    gpt_pre_last = GPT_LAST_64;
         default: gpt_pre_last = GPT_LAST_256;
      endcase
   endfunction

   function automatic logic [15:0] gpt_mask(input gpt_variant_e v);
      case (v)
         GPT_VAR_A: gpt_mask = GPT_MASK_A;
         GPT_VAR_B: gpt_mask = GPT_MASK_B;
         default:   gpt_mask = GPT_MASK_C;
      endcase
   endfunction

   // readback hides bits that the current clock source makes meaningless, save the gate bit of variant b
   function automatic logic [15:0] gpt_con_read(input gpt_variant_e v,
                                                input logic [15:0] raw);
      logic [15:0] r;
      r = raw & gpt_mask(v);
      if (v != GPT_VAR_B && r[GPT_SRC_BIT]) r[GPT_GATE_BIT] = 1'b0;
      if (v == GPT_VAR_A && !r[GPT_SRC_BIT]) r[GPT_SYNC_BIT] = 1'b0;
      gpt_con_read = r;
   endfunction
endpackage

/* File: core/gpt_tick_gen.sv */
`timescale 1ns/1ns
module gpt_tick_gen
   import gpt_pkg::*;
#(
   parameter gpt_variant_e VARIANT = GPT_VAR_A,
   parameter int           PRE_W   = 8
)(
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // count pin
   input wire logic pin,
   // settings and tick
   gpt_clk_if.unit  cfg
);
   generate
      if (PRE_W < 8) begin : g_bad_w
         $error("prescaler narrower than 256 counts");
      end
   endgenerate

   logic             pin_q;
   logic             sy1;
   logic             sy2;
   logic             sy3;
   logic             tgl;
   logic             t1;
   logic             t2;
   logic             t3;
   logic [PRE_W-1:0] pre_cnt;

   // *****************************
   // edge sources
   // *****************************
   wire             raw_edge   = pin & ~pin_q;
   wire             sync_edge  = sy2 & ~sy3;
   wire             gate_ok    = ~cfg.gate | sy2;  // [R20]
   // variant c synchronises ahead of the prescaler, b behind it, a behind it only when bit 2 is set
   wire             ext_edge   = (VARIANT == GPT_VAR_C) ? sync_edge : raw_edge;  // [R18] [R17]
   wire             pre_in     = cfg.run & (cfg.src ? ext_edge : gate_ok);  // [R7] [R3]
   wire [PRE_W-1:0] last       = PRE_W'(gpt_pre_last(cfg.pre_sel));
   // >= so that shrinking the ratio mid-count cannot strand the counter
   wire             pre_out    = pre_in & (pre_cnt >= last);  // [R4]
   wire             sync_after = cfg.src & ((VARIANT == GPT_VAR_B) |
                                 ((VARIANT == GPT_VAR_A) & cfg.sync));  // [R11] [R5]
   // a tick still in the sync pipe must not count once the timer stops
   assign cfg.tick = cfg.run & (sync_after ? (t2 ^ t3) : pre_out);  // [R5] [R13] [R1]

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         {pin_q, sy1, sy2, sy3} <= 4'h0;
      end else begin
         {pin_q, sy1, sy2, sy3} <= {pin, pin, sy1, sy2};
      end
   end

   // *****************************
   // prescaler and post-sync
   // *****************************
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pre_cnt <= '0;
      end else if (!cfg.run || pre_out) begin
         pre_cnt <= '0;
      end else if (pre_in) begin
         pre_cnt <= pre_cnt + PRE_W'(1);
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         {tgl, t1, t2, t3} <= 4'h0;
      end else begin
         tgl <= tgl ^ (pre_out & sync_after);
         {t1, t2, t3} <= {tgl, t1, t2};
      end
   end

   // *****************************
   // checks
   // *****************************
   sequence s_post_start;
      sync_after && pre_out;
   endsequence

   chk_prescale_step: assert property (@(posedge clock) disable iff (rst) // [R4]
      pre_in && cfg.run && pre_cnt < last |=> pre_cnt == $past(pre_cnt) + PRE_W'(1))
      else $error("prescaler did not advance");

   chk_sync_after_pre: assert property (@(posedge clock) disable iff (rst) // [R11]
      s_post_start ##1 (sync_after && cfg.run) [*3] |-> cfg.tick)
      else $error("post-prescaler sync tick missing");

   chk_async_direct: assert property (@(posedge clock) disable iff (rst) // [R5]
      VARIANT == GPT_VAR_A && cfg.src && !cfg.sync && pre_out |-> cfg.tick)
      else $error("unsynchronised tick delayed");
endmodule // gpt_tick_gen

/* File: core/gpt_timer.sv */
`timescale 1ns/1ns
// Function
// R1: bit 15 starts and stops counting
// R2: bit 13 halts counting during idle
// R3: bit 6 gates; gate reads zero externally (variant b still reads it back)
// R4: bits 5-4 prescale 1, 8, 64, 256
// R5: variant a bit 2 selects pin sync
// R6: internal clock: sync bit ignored, reads zero
// R7: bit 1 selects pin or internal clock
// R8: unimplemented control bits read as zero
// R9: variant b bit 3 forms 32-bit pair
// R10: variant b run bit drives pair
// R11: variant b syncs after the prescaler
// R12: variant c match triggers conversion
// R13: variant a counts slow oscillator, asynchronously
// R14: pinless timers count internal clock only
// R15: count, period, control registers read/write
// R16: internal 1:1 advances every cycle
// R17: external source counts pin rising edges
// R18: variants b and c always sync pin
// R19: match wraps to zero, sets flag
// R20: gated mode counts while gate high
module gpt_timer
   import gpt_pkg::*;
#(
   parameter logic [2:0] HAS_PIN  = 3'h7,
   parameter bit         A_LP_OSC = 1'b0
)(
   // clock and reset
   input  wire logic              clock,
   input  wire logic              rst,
   // register port
   input  wire logic [GPT_AW-1:0] addr,
   input  wire logic [GPT_DW-1:0] wr_data,
   input  wire logic              wr_en,
   input  wire logic              rd_en,
   output logic      [GPT_DW-1:0] rd_data,
   // pins and device state
   input  wire logic [2:0]        ext_count_pin,
   input  wire logic              lp_osc_in,
   input  wire logic              idle_mode,
   // events
   output logic      [2:0]        irq_flag_bit,
   output logic                   adc_trigger
);
   logic [15:0] con_a;
   logic [15:0] con_b;
   logic [15:0] con_c;
   logic [15:0] cnt_a;
   logic [15:0] cnt_b;
   logic [15:0] cnt_c;
   logic [15:0] per_a;
   logic [15:0] per_b;
   logic [15:0] per_c;

   gpt_clk_if if_a ();
   gpt_clk_if if_b ();
   gpt_clk_if if_c ();

   // *****************************
   // address decode
   // *****************************
   wire wr_cnt_a = wr_en && addr == GPT_CNT_A;
   wire wr_per_a = wr_en && addr == GPT_PER_A;
   wire wr_con_a = wr_en && addr == GPT_CON_A;
   wire wr_cnt_b = wr_en && addr == GPT_CNT_B;
   wire wr_per_b = wr_en && addr == GPT_PER_B;
   wire wr_con_b = wr_en && addr == GPT_CON_B;
   wire wr_cnt_c = wr_en && addr == GPT_CNT_C;
   wire wr_per_c = wr_en && addr == GPT_PER_C;
   wire wr_con_c = wr_en && addr == GPT_CON_C;
   wire wr_flags = wr_en && addr == GPT_FLAGS;

   // *****************************
   // control to clock paths
   // *****************************
   // the pair is run and halted from variant b alone
   wire pair  = con_b[GPT_PAIR_BIT];  // [R9]
   wire run_a = con_a[GPT_RUN_BIT] & ~(con_a[GPT_HALT_BIT] & idle_mode);  // [R1] [R2]
   wire run_b = con_b[GPT_RUN_BIT] & ~(con_b[GPT_HALT_BIT] & idle_mode);  // [R1] [R10] [R2]
   wire run_c = con_c[GPT_RUN_BIT] & ~(con_c[GPT_HALT_BIT] & idle_mode) & ~pair;  // [R1]
   // without a pin the source bit is overruled; a pair draws from b
   wire src_a = con_a[GPT_SRC_BIT] & HAS_PIN[0];  // [R14]
   wire src_b = con_b[GPT_SRC_BIT] & HAS_PIN[1];  // [R14]
   wire src_c = con_c[GPT_SRC_BIT] & HAS_PIN[2];  // [R14]
   // slow oscillator feeds variant a in place of its pin when strapped
   wire pin_a = A_LP_OSC ? lp_osc_in : ext_count_pin[0];  // [R13]

   assign if_a.run     = run_a;
   assign if_a.src     = src_a;
   assign if_a.gate    = con_a[GPT_GATE_BIT] & ~src_a;  // [R3]
   assign if_a.sync    = con_a[GPT_SYNC_BIT] & src_a;  // [R6]
   assign if_a.pre_sel = con_a[GPT_PRE_HI:GPT_PRE_LO];
   assign if_b.run     = run_b;
   assign if_b.src     = src_b;
   assign if_b.gate    = con_b[GPT_GATE_BIT] & ~src_b;  // [R3]
   assign if_b.sync    = 1'b1;  // [R18]
   assign if_b.pre_sel = con_b[GPT_PRE_HI:GPT_PRE_LO];
   assign if_c.run     = run_c;
   assign if_c.src     = src_c;
   assign if_c.gate    = con_c[GPT_GATE_BIT] & ~src_c;  // [R3]
   assign if_c.sync    = 1'b1;  // [R18]
   assign if_c.pre_sel = con_c[GPT_PRE_HI:GPT_PRE_LO];

   gpt_tick_gen #(.VARIANT(GPT_VAR_A), .PRE_W(8)) u_tick_a (
      .clock (clock),
      .rst   (rst),
      .pin   (pin_a),
      .cfg   (if_a)
   );
   gpt_tick_gen #(.VARIANT(GPT_VAR_B), .PRE_W(8)) u_tick_b (
      .clock (clock),
      .rst   (rst),
      .pin   (ext_count_pin[1]),
      .cfg   (if_b)
   );
   gpt_tick_gen #(.VARIANT(GPT_VAR_C), .PRE_W(8)) u_tick_c (
      .clock (clock),
      .rst   (rst),
      .pin   (ext_count_pin[2]),
      .cfg   (if_c)
   );

   // *****************************
   // counters
   // *****************************
   wire [31:0] wide_cnt = {cnt_c, cnt_b};
   wire [31:0] wide_per = {per_c, per_b};
   wire        match_a  = if_a.tick & (cnt_a == per_a);  // [R19]
   wire        match_b  = ~pair & if_b.tick & (cnt_b == per_b);  // [R19]
   wire        match_c  = ~pair & if_c.tick & (cnt_c == per_c);  // [R19]
   wire        match_w  = pair & if_b.tick & (wide_cnt == wide_per);  // [R9] [R19]
   wire [31:0] wide_nxt = match_w ? 32'h0 : wide_cnt + 32'h1;

   logic [15:0] next_cnt_a;
   logic [15:0] next_cnt_b;
   logic [15:0] next_cnt_c;

   // a software write wins over a tick in the same cycle
   always_comb begin
      next_cnt_a = cnt_a;
      if (wr_cnt_a) begin
         next_cnt_a = wr_data;
      end else if (if_a.tick) begin
         next_cnt_a = match_a ? 16'h0 : cnt_a + 16'h1;  // [R16] [R19]
      end
   end

   always_comb begin
      next_cnt_b = cnt_b;
      if (wr_cnt_b) begin
         next_cnt_b = wr_data;
      end else if (pair && if_b.tick) begin
         next_cnt_b = wide_nxt[15:0];  // [R9]
      end else if (!pair && if_b.tick) begin
         next_cnt_b = match_b ? 16'h0 : cnt_b + 16'h1;  // [R19]
      end
   end

   always_comb begin
      next_cnt_c = cnt_c;
      if (wr_cnt_c) begin
         next_cnt_c = wr_data;
      end else if (pair && if_b.tick) begin
         next_cnt_c = wide_nxt[31:16];  // [R9] [R10]
      end else if (!pair && if_c.tick) begin
         next_cnt_c = match_c ? 16'h0 : cnt_c + 16'h1;  // [R19]
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cnt_a <= GPT_CNT_RST;
         cnt_b <= GPT_CNT_RST;
         cnt_c <= GPT_CNT_RST;
      end else begin
         cnt_a <= next_cnt_a;
         cnt_b <= next_cnt_b;
         cnt_c <= next_cnt_c;
      end
   end

   // *****************************
   // register file
   // *****************************
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         con_a <= GPT_CON_RST;
         con_b <= GPT_CON_RST;
         con_c <= GPT_CON_RST;
      end else begin
         if (wr_con_a) con_a <= wr_data & GPT_MASK_A;  // [R8]
         if (wr_con_b) con_b <= wr_data & GPT_MASK_B;  // [R8]
         if (wr_con_c) con_c <= wr_data & GPT_MASK_C;  // [R8]
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         per_a <= GPT_PER_RST;
         per_b <= GPT_PER_RST;
         per_c <= GPT_PER_RST;
      end else begin
         if (wr_per_a) per_a <= wr_data;  // [R15]
         if (wr_per_b) per_b <= wr_data;  // [R15]
         if (wr_per_c) per_c <= wr_data;  // [R15]
      end
   end

   // in pair mode the match belongs to the upper half
   wire [2:0] flag_set = {match_c | match_w, match_b, match_a};
   wire [2:0] flag_clr = wr_flags ? wr_data[2:0] : 3'h0;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         irq_flag_bit <= 3'h0;
         adc_trigger  <= 1'b0;
      end else begin
         irq_flag_bit <= (irq_flag_bit & ~flag_clr) | flag_set;  // [R19]
         adc_trigger  <= match_c | match_w;  // [R12]
      end
   end

   // *****************************
   // read path
   // *****************************
   logic [15:0] rd_mux;

   always_comb begin
      unique case (addr)
         GPT_CNT_A: rd_mux = cnt_a;  // [R15]
         GPT_PER_A: rd_mux = per_a;
         GPT_CON_A: rd_mux = gpt_con_read(GPT_VAR_A, con_a);  // [R3] [R6] [R8]
         GPT_CNT_B: rd_mux = cnt_b;
         GPT_PER_B: rd_mux = per_b;
         GPT_CON_B: rd_mux = gpt_con_read(GPT_VAR_B, con_b);  // [R8]
         GPT_CNT_C: rd_mux = cnt_c;
         GPT_PER_C: rd_mux = per_c;
         GPT_CON_C: rd_mux = gpt_con_read(GPT_VAR_C, con_c);  // [R3] [R8]
         GPT_FLAGS: rd_mux = {13'h0, irq_flag_bit};
         default:   rd_mux = 16'h0;
      endcase
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rd_data <= 16'h0;
      end else begin
         rd_data <= rd_en ? rd_mux : 16'h0;
      end
   end

   // *****************************
   // checks
   // *****************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   sequence s_free_run_a;
      run_a && !src_a && !con_a[GPT_GATE_BIT] && con_a[GPT_PRE_HI:GPT_PRE_LO] == 2'h0
         && !wr_cnt_a && !wr_con_a;
   endsequence

   chk_stop_holds: assert property ( // [R1]
      !con_a[GPT_RUN_BIT] && !wr_cnt_a |=> cnt_a == $past(cnt_a))
      else $error("stopped timer changed count");

   chk_idle_halt: assert property ( // [R2]
      con_b[GPT_HALT_BIT] && idle_mode && !wr_cnt_b && !wr_cnt_c |=> $stable(cnt_b))
      else $error("timer counted while idle-halted");

   chk_gate_reads_zero: assert property ( // [R3]
      rd_en && addr == GPT_CON_C && con_c[GPT_SRC_BIT] |=> !rd_data[GPT_GATE_BIT])
      else $error("gate bit visible with external source");

   chk_sync_reads_zero: assert property ( // [R6]
      rd_en && addr == GPT_CON_A && !con_a[GPT_SRC_BIT] |=> !rd_data[GPT_SYNC_BIT])
      else $error("sync bit visible with internal source");

   chk_unimpl_zero: assert property ( // [R8]
      rd_en && addr == GPT_CON_B |=> (rd_data & ~GPT_MASK_B) == 16'h0)
      else $error("unimplemented bit read as one");

   chk_free_run_rate: assert property ( // [R16]
      s_free_run_a ##1 s_free_run_a ##0 (cnt_a != per_a)
         |=> cnt_a == $past(cnt_a) + 16'h1)
      else $error("internal 1:1 count missed a cycle");

   chk_wrap_and_flag: assert property ( // [R19]
      match_a && !wr_cnt_a |=> cnt_a == 16'h0 && irq_flag_bit[0])
      else $error("period match did not wrap and flag");

   chk_pair_carry: assert property ( // [R9]
      pair && if_b.tick && !match_w && cnt_b == 16'hffff && !wr_cnt_b && !wr_cnt_c
         |=> cnt_c == $past(cnt_c) + 16'h1 && cnt_b == 16'h0)
      else $error("pair carry lost");

   chk_adc_pulse: assert property ( // [R12]
      (match_c || match_w) |=> adc_trigger ##1 !(adc_trigger && !$past(match_c || match_w)))
      else $error("conversion trigger not a match pulse");

   chk_flag_set_wins: assert property ( // [R19]
      match_a && wr_flags && wr_data[0] |=> irq_flag_bit[0])
      else $error("flag clear beat a match");
endmodule // gpt_timer

/* File: test/gpt_pin_src.sv */
`timescale 1ns/1ns
module gpt_pin_src #(
   parameter int HALF = 4
)(
   // clock and reset
   input  wire logic       clock,
   input  wire logic       rst,
   // per pin: 0 low, 1 high, 2 free-running count clock
   input  wire logic [5:0] pin_mode,
   // count or gate pins
   output logic      [2:0] pins
);
   int   phase;
   logic wave;

   // ***************************
   // free-running count clock
   // ***************************
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         phase <= 0;
         wave  <= 1'b0;
      end else if (phase == HALF - 1) begin
         phase <= 0;
         wave  <= ~wave;
      end else begin
         phase <= phase + 1;
      end
   end

   // ***************************
   // pin levels
   // ***************************
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         case (pin_mode[2*i +: 2])
            2'h0:    pins[i] = 1'b0;
            2'h1:    pins[i] = 1'b1;
            default: pins[i] = wave;
         endcase
      end
   end
endmodule // gpt_pin_src

/* File: test/gpt_timer_bench.sv */
`timescale 1ns/1ns
module gpt_timer_bench;
   import gpt_pkg::*;
   logic        clock;
   logic        rst;
   logic [3:0]  addr;
   logic [15:0] wr_data;
   logic        wr_en;
   logic        rd_en;
   logic [15:0] rd_data;
   logic [2:0]  pins;
   logic [5:0]  pin_mode;
   logic        idle_mode;
   logic [2:0]  irq_flag_bit;
   logic        adc_trigger;
   int          bad_count;
   int          checks;
   int          cycles;
   int          trig_count;
   logic [15:0] d;
   int          t0;
   logic [3:0]  cons [3] = '{GPT_CON_A, GPT_CON_B, GPT_CON_C};
   logic [3:0]  cnts [3] = '{GPT_CNT_A, GPT_CNT_B, GPT_CNT_C};
   logic [15:0] ev [6] = '{16'h2036, 16'h207a, 16'h2032, 16'h2070, 16'h2078, 16'h2070};
   int          divs [4] = '{1, 8, 64, 256};

   gpt_timer gpt_timer_i (.clock(clock), .rst(rst), .addr(addr), .wr_data(wr_data),
      .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .ext_count_pin(pins),
      .lp_osc_in(1'b0), .idle_mode(idle_mode), .irq_flag_bit(irq_flag_bit),
      .adc_trigger(adc_trigger));

   gpt_pin_src gpt_pin_src_i (.clock(clock), .rst(rst), .pin_mode(pin_mode), .pins(pins));

   // ***************************
   // clock, timeout, trigger count
   // ***************************
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (adc_trigger === 1'b1) trig_count <= trig_count + 1;
      if (cycles == 20000) begin
         bad_count++;
         report_and_stop();
      end
   end

   // ***************************
   // bus tasks and compare
   // ***************************
   // tasks start just after an edge so strobes may run back to back
   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      addr    <= a;
      wr_data <= v;
      wr_en   <= 1'b1;
      @(posedge clock);
      wr_en   <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [3:0] a, output logic [15:0] v);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge clock);
      rd_en <= 1'b0;
      #1;
      v = rd_data;
   endtask

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
         bad_count++;
      end
   endtask

   // two reads exactly span cycles apart, so the prescaler phase cannot skew the delta
   task automatic rate(input int t, input logic [15:0] con, input int span, input int exp);
      logic [15:0] d1;
      logic [15:0] d2;
      wr(cons[t], con);
      repeat (40) @(posedge clock);
      #1;
      rd(cnts[t], d1);
      repeat (span - 1) @(posedge clock);
      #1;
      rd(cnts[t], d2);
      check(d2 - d1, exp[15:0]);
      wr(cons[t], 16'h0000);
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // ***************************
   // tests
   // ***************************
   initial begin
      rst = 1'b1;
      addr = 4'h0;
      wr_data = 16'h0000;
      wr_en = 1'b0;
      rd_en = 1'b0;
      idle_mode = 1'b0;
      pin_mode = 6'h2a;
      bad_count = 0;
      checks = 0;
      cycles = 0;
      trig_count = 0;
      repeat (12) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      #1;
      // index 10 is unmapped and must read zero
      for (int i = 0; i < 11; i++) begin
         rd(i[3:0], d);
         check(d, (i == 1 || i == 4 || i == 7) ? GPT_PER_RST : 16'h0000);
      end
      $display("test reset_values done");
      for (int j = 0; j < 2; j++) begin
         for (int v = 0; v < 3; v++) begin
            wr(cons[v], (j == 0) ? 16'h7fff : 16'h7ffd);
            rd(cons[v], d);
            check(d, ev[3*j+v]);
            wr(cons[v], 16'h0000);
         end
      end
      $display("test control_readback done");
      for (int p = 0; p < 4; p++) begin
         rate(0, 16'h8000 | 16'(p << 4), 4 * divs[p], 4);
      end
      for (int t = 1; t < 3; t++) rate(t, 16'h8000, 20, 20);
      $display("test prescale done");
      rate(0, 16'h0000, 20, 0);
      idle_mode <= 1'b1;
      rate(0, 16'ha000, 20, 0);
      rate(1, 16'ha000, 20, 0);
      rate(0, 16'h8000, 20, 20);
      idle_mode <= 1'b0;
      $display("test run_idle done");
      // pins rise every 8 cycles
      rate(0, 16'h8002, 64, 8);
      rate(0, 16'h8006, 64, 8);
      rate(1, 16'h8002, 64, 8);
      rate(2, 16'h8002, 64, 8);
      rate(1, 16'h8012, 128, 2);
      $display("test external done");
      pin_mode <= 6'h28;
      rate(0, 16'h8040, 20, 0);
      pin_mode <= 6'h29;
      rate(0, 16'h8040, 20, 20);
      pin_mode <= 6'h1a;
      rate(2, 16'h8040, 20, 20);
      pin_mode <= 6'h2a;
      $display("test gate done");
      // period 6: the sixth clear lands on the match edge, so the flag must stay
      wr(GPT_PER_A, 16'h0005);
      wr(GPT_CNT_A, 16'h0000);
      wr(GPT_CON_A, 16'h8000);
      repeat (6) wr(GPT_FLAGS, 16'h0001);
      wr(GPT_CON_A, 16'h0000);
      rd(GPT_FLAGS, d);
      check(d, 16'h0001);
      wr(GPT_FLAGS, 16'h0007);
      wr(GPT_CNT_C, 16'h0000);
      wr(GPT_PER_C, 16'h0005);
      wr(GPT_CON_C, 16'h8000);
      repeat (30) @(posedge clock);
      #1;
      t0 = trig_count;
      repeat (60) @(posedge clock);
      #1;
      check(16'(trig_count - t0), 16'h000a);
      rd(GPT_FLAGS, d);
      check(d, 16'h0004);
      check({13'h0, irq_flag_bit}, 16'h0004);
      wr(GPT_CON_C, 16'h0000);
      wr(GPT_FLAGS, 16'h0007);
      rd(GPT_FLAGS, d);
      check(d, 16'h0000);
      $display("test period_match done");
      wr(GPT_PER_C, 16'hffff);
      wr(GPT_CNT_B, 16'hfff0);
      wr(GPT_CNT_C, 16'h0000);
      wr(GPT_CON_B, 16'h8008);
      repeat (40) @(posedge clock);
      #1;
      wr(GPT_CON_B, 16'h0008);
      rd(GPT_CNT_C, d);
      check(d, 16'h0001);
      rate(1, 16'h0008, 20, 0);
      wr(GPT_CON_B, 16'h0008);
      rate(2, 16'h8000, 20, 0);
      wr(GPT_CON_B, 16'h0000);
      $display("test pair done");
      report_and_stop();
   end
endmodule // gpt_timer_bench
